/* File: rtl/tps_pkg.sv */
// package: register map, field layout, reset values and state codes of the playback sequencer
package tps_pkg;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] TPS_OFS_CTRL = 8'h00;
  localparam logic [7:0] TPS_OFS_CFG = 8'h04;
  localparam logic [7:0] TPS_OFS_STATUS = 8'h08;
  localparam logic [7:0] TPS_OFS_REPEAT = 8'h0C;
  localparam logic [7:0] TPS_OFS_WAVE_LEN = 8'h10;
  localparam logic [7:0] TPS_OFS_MEM_ADDR = 8'h14;
  localparam logic [7:0] TPS_OFS_MEM_DATA = 8'h18;
  localparam logic [7:0] TPS_OFS_SEG_SEL = 8'h1C;
  localparam logic [7:0] TPS_OFS_SEG_START = 8'h20;
  localparam logic [7:0] TPS_OFS_SEG_LEN = 8'h24;
  localparam logic [7:0] TPS_OFS_SEG_LOOPS = 8'h28;
  localparam logic [7:0] TPS_OFS_SEG_COUNT = 8'h2C;
  localparam logic [7:0] TPS_OFS_SW_TRIG = 8'h30;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int TPS_CTRL_INIT_BIT = 0;
  localparam int TPS_CTRL_ABORT_BIT = 1;
  localparam int TPS_CFG_STEPPED_BIT = 0;
  localparam int TPS_CFG_LIST_BIT = 1;
  localparam int TPS_CFG_SRC_LSB = 2;
  localparam int TPS_CFG_FALL_BIT = 4;
  localparam int TPS_CFG_LINE_LSB = 5;
  localparam int TPS_SW_TRIG_BIT = 0;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] TPS_CFG_RST = 8'h00;
  localparam logic [15:0] TPS_REPEAT_RST = 16'h0001;
  localparam logic [15:0] TPS_LOOPS_RST = 16'h0001;

  // ***************************************************************
  // trigger sources and sequencer states
  // ***************************************************************
  localparam logic [1:0] TPS_SRC_IMM = 2'h0;
  localparam logic [1:0] TPS_SRC_EXT = 2'h1;
  localparam logic [1:0] TPS_SRC_BP = 2'h2;
  localparam logic [1:0] TPS_SRC_SW = 2'h3;

  // gray order along idle -> armed -> run -> hold
  typedef enum logic [1:0] {
    TPS_IDLE = 2'b00,
    TPS_ARMED = 2'b01,
    TPS_RUN = 2'b11,
    TPS_HOLD = 2'b10
  } tps_state_t;

endpackage

/* File: rtl/tps_sequencer.sv */
// module: trigger mode playback sequencer with wishbone register slave
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// R01: continuous mode with one waveform starts on the first accepted trigger and loops forever.
// R02: in continuous mode every trigger after the launching one is ignored.
// R03: continuous list mode plays first to last segment, then wraps and repeats forever.
// R04: stepped mode plays the waveform once per accepted trigger and again on later ones.
// R05: after a stepped play ends the final sample is held on every sample until a trigger.
// R06: stepped triggers during playback are discarded; only ones after the last sample count.
// R07: stepped single waveform plays waveform_repeat_total times back to back per trigger.
// R08: stepped list mode plays only the next segment per accepted trigger.
// R09: each stepped segment plays its own loop count before halting on its last sample.
// R10: after the last segment the pointer returns to the first one for the next triggers.
// R11: an accepted trigger moves the sequencer from armed into generating on sample ticks.
// R12: all triggers are ignored until an initiate command arms the sequencer.
// R13: the immediate source, the default, makes its own trigger as soon as it is armed.
// R14: the chosen trigger is synchronised and reduced to a one-cycle pulse first.
// R15: software loads memory, segments, mode and repeat count before initiating.
module tps_sequencer
  import tps_pkg::*;
#(
  parameter int SW = 16,
  parameter int DEPTH = 64,
  parameter int NSEG = 8,
  parameter int SAMPLE_DIV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_trig_i,
  input wire logic [7:0] bp_trig_i,
  output logic [SW-1:0] sample_o,
  output logic sample_valid_o,
  output logic generating_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int SIW = $clog2(NSEG);
  localparam int DW = $clog2(SAMPLE_DIV + 1);

  // ***************************************************************
  // helpers
  // ***************************************************************
  // merge only the enabled byte lanes into the old value
  function automatic logic [31:0] f_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // a count of zero is taken as one
  function automatic logic [15:0] f_min1(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  // ***************************************************************
  // sample rate divider
  // ***************************************************************
  logic [DW-1:0] div_q;
  logic tick_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DW'(SAMPLE_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ***************************************************************
  // register file
  // ***************************************************************
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] cfg_q;
  logic [15:0] waveform_repeat_total_q;
  logic [AW:0] wave_len_q;
  logic [AW-1:0] mem_addr_q;
  logic [SIW-1:0] seg_sel_q;
  logic [SIW:0] seg_count_q;
  logic [AW-1:0] seg_start_q [NSEG];
  logic [AW:0] seg_len_q [NSEG];
  logic [15:0] seg_loops_q [NSEG];
  logic [SW-1:0] mem_q [DEPTH];
  tps_state_t state_q;
  logic [SIW-1:0] seg_idx_q;
  logic [31:0] rdata_c;
  logic [31:0] wval;
  logic wr;
  logic init_cmd;
  logic abort_cmd;
  logic sw_trig;

  // readback mux; unmapped offsets read zero but still acknowledge
  always_comb begin
    case (wb_adr_i)
      TPS_OFS_CFG: rdata_c = 32'(cfg_q);
      TPS_OFS_STATUS: rdata_c = {16'h0000, 8'(seg_idx_q), 6'h00, state_q};
      TPS_OFS_REPEAT: rdata_c = 32'(waveform_repeat_total_q);
      TPS_OFS_WAVE_LEN: rdata_c = 32'(wave_len_q);
      TPS_OFS_MEM_ADDR: rdata_c = 32'(mem_addr_q);
      TPS_OFS_MEM_DATA: rdata_c = 32'(mem_q[mem_addr_q]);
      TPS_OFS_SEG_SEL: rdata_c = 32'(seg_sel_q);
      TPS_OFS_SEG_START: rdata_c = 32'(seg_start_q[seg_sel_q]);
      TPS_OFS_SEG_LEN: rdata_c = 32'(seg_len_q[seg_sel_q]);
      TPS_OFS_SEG_LOOPS: rdata_c = 32'(seg_loops_q[seg_sel_q]);
      TPS_OFS_SEG_COUNT: rdata_c = 32'(seg_count_q);
      default: rdata_c = 32'h0000_0000;
    endcase
  end

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign wval = f_lanes(rdata_c, wb_dat_i, wb_sel_i);
  assign init_cmd = wr && (wb_adr_i == TPS_OFS_CTRL) && wval[TPS_CTRL_INIT_BIT];
  assign abort_cmd = wr && (wb_adr_i == TPS_OFS_CTRL) && wval[TPS_CTRL_ABORT_BIT];
  assign sw_trig = wr && (wb_adr_i == TPS_OFS_SW_TRIG) && wval[TPS_SW_TRIG_BIT];

  // one wait state per access; ack drops the cycle after it rose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      dat_q <= rdata_c;
    end
  end

  // configuration registers; changing them mid-play takes effect at the next load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= TPS_CFG_RST;
      waveform_repeat_total_q <= TPS_REPEAT_RST;
      wave_len_q <= '0;
      mem_addr_q <= '0;
      seg_sel_q <= '0;
      seg_count_q <= (SIW + 1)'(1);
      for (int i = 0; i < NSEG; i++) begin
        seg_start_q[i] <= '0;
        seg_len_q[i] <= '0;
        seg_loops_q[i] <= TPS_LOOPS_RST;
      end
    end else if (wr) begin
      case (wb_adr_i)
        TPS_OFS_CFG: cfg_q <= wval[7:0];
        TPS_OFS_REPEAT: waveform_repeat_total_q <= wval[15:0];
        TPS_OFS_WAVE_LEN: wave_len_q <= wval[AW:0];
        TPS_OFS_MEM_ADDR: mem_addr_q <= wval[AW-1:0];
        TPS_OFS_MEM_DATA: mem_addr_q <= mem_addr_q + 1'b1; // auto increment for bulk loads
        TPS_OFS_SEG_SEL: seg_sel_q <= wval[SIW-1:0];
        TPS_OFS_SEG_START: seg_start_q[seg_sel_q] <= wval[AW-1:0];
        TPS_OFS_SEG_LEN: seg_len_q[seg_sel_q] <= wval[AW:0];
        TPS_OFS_SEG_LOOPS: seg_loops_q[seg_sel_q] <= wval[15:0];
        TPS_OFS_SEG_COUNT: seg_count_q <= wval[SIW:0];
        default: ;
      endcase
    end
  end

  // waveform storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (wr && (wb_adr_i == TPS_OFS_MEM_DATA)) begin
      mem_q[mem_addr_q] <= wval[SW-1:0];
    end
  end

  // ***************************************************************
  // start trigger conditioning
  // ***************************************************************
  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic prev_q;
  logic trig_q;
  logic lvl;
  logic [1:0] src;
  logic stepped;
  logic use_list;

  assign src = cfg_q[TPS_CFG_SRC_LSB +: 2];
  assign stepped = cfg_q[TPS_CFG_STEPPED_BIT];
  assign use_list = cfg_q[TPS_CFG_LIST_BIT];
  assign lvl = (src == TPS_SRC_EXT) ? sync2_q[0] : sync2_q[4'(cfg_q[TPS_CFG_LINE_LSB +: 3]) + 4'h1];

  // two-stage synchroniser, then one-cycle edge pulse [R14]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      sync1_q <= {bp_trig_i, ext_trig_i};
      sync2_q <= sync1_q;
      prev_q <= lvl;
      trig_q <= (((src == TPS_SRC_EXT) || (src == TPS_SRC_BP)) &&
                 (cfg_q[TPS_CFG_FALL_BIT] ? (prev_q && !lvl) : (!prev_q && lvl))) ||
                ((src == TPS_SRC_SW) && sw_trig); // [R14]
    end
  end

  // ***************************************************************
  // trigger acceptance
  // ***************************************************************
  logic pend_q;
  logic window;
  logic consume;

  // a pulse waits for the next sample tick, since ticks come only every SAMPLE_DIV clocks;
  // in run it is simply dropped
  assign consume = tick_q && pend_q;
  assign window = ((state_q == TPS_ARMED) || (stepped && (state_q == TPS_HOLD))) && !consume;

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_cmd) begin
      pend_q <= 1'b0;
    end else if (window && (trig_q || pend_q ||
                            ((state_q == TPS_ARMED) && (src == TPS_SRC_IMM)))) begin
      pend_q <= 1'b1; // [R12] [R13] [R04] [R06]
    end else begin
      pend_q <= 1'b0; // [R02] [R06]
    end
  end

  // ***************************************************************
  // playback sequencer
  // ***************************************************************
  logic [AW-1:0] addr_q;
  logic [15:0] smp_left_q;
  logic [15:0] loops_left_q;
  logic [SW-1:0] sample_q;
  logic valid_q;
  logic gen_q;
  logic [AW-1:0] cur_start;
  logic [15:0] cur_len;
  logic [15:0] cur_loops;
  logic [SIW:0] inc_idx;
  logic [SIW-1:0] nxt_idx;
  logic seg_end;

  assign cur_start = use_list ? seg_start_q[seg_idx_q] : '0;
  assign cur_len = f_min1(16'(use_list ? seg_len_q[seg_idx_q] : wave_len_q));
  assign cur_loops = f_min1(use_list ? seg_loops_q[seg_idx_q] :
                            (stepped ? waveform_repeat_total_q : 16'h0001));
  assign inc_idx = {1'b0, seg_idx_q} + 1'b1;
  assign nxt_idx = (inc_idx >= seg_count_q) ? '0 : inc_idx[SIW-1:0];
  assign seg_end = tick_q && (state_q == TPS_RUN) && (smp_left_q == 16'h0000) &&
                   (loops_left_q <= 16'h0001);

  // state, pointers and counters advance only on sample ticks, apart from initiate moving idle to armed and abort clearing to idle
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_cmd) begin
      state_q <= TPS_IDLE;
      seg_idx_q <= '0;
      addr_q <= '0;
      smp_left_q <= '0;
      loops_left_q <= '0;
      sample_q <= '0;
    end else if (init_cmd && (state_q == TPS_IDLE)) begin
      state_q <= TPS_ARMED; // [R12]
      seg_idx_q <= '0;
    end else if (tick_q) begin
      case (state_q)
        TPS_ARMED, TPS_HOLD: begin
          if (pend_q) begin
            state_q <= TPS_RUN; // [R11] [R04]
            addr_q <= cur_start;
            smp_left_q <= cur_len - 16'h0001;
            loops_left_q <= cur_loops; // [R07] [R09]
          end
        end
        TPS_RUN: begin
          sample_q <= mem_q[addr_q];
          if (smp_left_q != 16'h0000) begin
            addr_q <= addr_q + 1'b1;
            smp_left_q <= smp_left_q - 16'h0001;
          end else if (loops_left_q > 16'h0001) begin
            addr_q <= cur_start; // [R07] [R09]
            smp_left_q <= cur_len - 16'h0001;
            loops_left_q <= loops_left_q - 16'h0001;
          end else if (!stepped && use_list) begin
            seg_idx_q <= nxt_idx; // [R03]
            addr_q <= seg_start_q[nxt_idx];
            smp_left_q <= f_min1(16'(seg_len_q[nxt_idx])) - 16'h0001;
            loops_left_q <= f_min1(seg_loops_q[nxt_idx]);
          end else if (!stepped) begin
            addr_q <= cur_start; // [R01]
            smp_left_q <= cur_len - 16'h0001;
            loops_left_q <= cur_loops;
          end else begin
            state_q <= TPS_HOLD; // [R05]
            if (use_list) begin
              seg_idx_q <= nxt_idx; // [R08] [R10]
            end
          end
        end
        default: ;
      endcase
    end
  end

  // output stream: hold keeps the last sample, armed sends nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      gen_q <= 1'b0;
    end else begin
      valid_q <= tick_q && ((state_q == TPS_RUN) || (state_q == TPS_HOLD)); // [R05]
      gen_q <= (state_q == TPS_RUN);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sample_o = sample_q;
  assign sample_valid_o = valid_q;
  assign generating_o = gen_q;

  // ***************************************************************
  // assertions
  // ***************************************************************
  localparam int A_IMM_MAX = 8;

  a_idle_ignores: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (state_q == TPS_IDLE) && !init_cmd |=> (state_q == TPS_IDLE))
    else $error("left idle without initiate");
  a_trig_single: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    trig_q |=> !trig_q)
    else $error("trigger pulse longer than one cycle");
  a_arm_to_run: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (state_q == TPS_ARMED) && consume && !abort_cmd |=> (state_q == TPS_RUN) && gen_q == 1'b0 ##1 gen_q)
    else $error("accepted trigger did not start generation");
  a_run_drops: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
    (state_q == TPS_RUN) |-> !pend_q)
    else $error("trigger held during playback");
  a_cont_forever: assert property (@(posedge clk_i) disable iff (rst_i) // [R01] [R03]
    (state_q == TPS_RUN) && !stepped && !abort_cmd && $stable(cfg_q) |=> (state_q == TPS_RUN))
    else $error("continuous playback stopped");
  a_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
    (state_q == TPS_HOLD) [*2] |-> $stable(sample_q))
    else $error("held sample changed");
  a_imm_start: assert property (@(posedge clk_i) disable iff (rst_i || abort_cmd) // [R13]
    (state_q == TPS_ARMED) && (src == TPS_SRC_IMM) && $stable(cfg_q) |-> ##[1:A_IMM_MAX]
    (state_q == TPS_RUN))
    else $error("immediate trigger did not start");
  a_step_advance: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
    seg_end && stepped && use_list && !abort_cmd |=>
    (state_q == TPS_HOLD) && (seg_idx_q == $past(nxt_idx)))
    else $error("stepped segment did not advance");
  a_list_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    seg_end && use_list && !abort_cmd && (inc_idx >= seg_count_q) |=> (seg_idx_q == '0))
    else $error("segment pointer did not wrap");
  a_loop_count: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
    tick_q && (state_q == TPS_RUN) && (smp_left_q == 16'h0000) && (loops_left_q > 16'h0001) &&
    !abort_cmd |=> (state_q == TPS_RUN) && (loops_left_q == $past(loops_left_q) - 16'h0001))
    else $error("loop count not honoured");
  a_cont_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
    seg_end && !stepped && use_list && !abort_cmd |=> (state_q == TPS_RUN))
    else $error("continuous list stopped at segment end");

  c_cont_loop: cover property (@(posedge clk_i) disable iff (rst_i)
    seg_end && !stepped && !use_list);
  c_step_hold: cover property (@(posedge clk_i) disable iff (rst_i)
    (state_q == TPS_HOLD) && consume);
  c_list_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
    seg_end && use_list && (inc_idx >= seg_count_q));
  c_run_trig: cover property (@(posedge clk_i) disable iff (rst_i)
    (state_q == TPS_RUN) && trig_q);

endmodule

`default_nettype wire

/* File: testbench/tps_partner.sv */
// partner model: start trigger source on the external and backplane trigger pins
`timescale 1ns/1ps
`default_nettype none

module tps_partner (
  input wire logic clk_i,
  output logic ext_trig_o,
  output logic [7:0] bp_trig_o
);

  // ******************************************************
  // trigger pins rest low between pulses
  // ******************************************************
  initial begin
    ext_trig_o = 1'b0;
    bp_trig_o = 8'h00;
  end

  // four clocks wide, so the two-flop synchroniser cannot miss an edge
  task automatic pulse_ext();
    @(posedge clk_i);
    ext_trig_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    ext_trig_o <= 1'b0;
  endtask

  // the falling edge at the end is the one a falling-edge setting acts on
  task automatic pulse_bp(input int line);
    @(posedge clk_i);
    bp_trig_o[line] <= 1'b1;
    repeat (4) @(posedge clk_i);
    bp_trig_o[line] <= 1'b0;
  endtask

endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
// testbench: bus tasks, expectations and scenarios for the playback sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import tps_pkg::*;

  // ******************************************************
  // clock, reset, bus and pin signals
  // ******************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_trig;
  logic [7:0] bp_trig;
  logic [15:0] sample_o;
  logic sample_valid_o;
  logic generating_o;
  logic [15:0] mem_ref [8];
  int err_count = 0;
  int check_count = 0;

  always #2.5 clk_i = ~clk_i;

  tps_sequencer #(.SAMPLE_DIV(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_trig_i(ext_trig), .bp_trig_i(bp_trig), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o), .generating_o(generating_o)
  );

  tps_partner u_src (.clk_i(clk_i), .ext_trig_o(ext_trig), .bp_trig_o(bp_trig));

  // ******************************************************
  // helpers: random source, expectations, bus and checks
  // ******************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'h80200003) : (v >> 1);
  endfunction

  // sample expected at position i of a play, wrapping back to b every l samples
  function automatic logic [15:0] exp_smp(input int b, input int l, input int i);
    return mem_ref[b + i % l];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hF, r);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hF, r);
    chk(nm, e, r);
  endtask

  task automatic seg(input int i, input int st, input int l, input int lp);
    wr(TPS_OFS_SEG_SEL, i);
    wr(TPS_OFS_SEG_START, st);
    wr(TPS_OFS_SEG_LEN, l);
    wr(TPS_OFS_SEG_LOOPS, lp);
  endtask

  task automatic next_valid();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sample_valid_o !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
  endtask

  // l samples from b, r times, then h held samples; wt waits for generation
  task automatic play(input int b, input int l, input int r, input int h, input bit wt);
    int n;
    n = 0;
    while (wt && generating_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) err_count++;
    for (int i = 0; i < l * r + h; i++) begin
      next_valid();
      chk("sample", {16'h0, exp_smp(b, l, i < l * r ? i : l - 1)}, {16'h0, sample_o});
    end
  endtask

  task automatic test_end(input string nm);
    $display("test %s done, mismatches so far %0d", nm, err_count);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ******************************************************
  // scenarios
  // ******************************************************
  // generous bound: the scenarios need under two thousand cycles
  initial begin
    #100000;
    err_count++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    logic [31:0] s;
    logic [31:0] r;
    s = 32'h4AACD54B;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("cfg", TPS_OFS_CFG, {24'h0, TPS_CFG_RST});
    rdchk("repeat", TPS_OFS_REPEAT, {16'h0, TPS_REPEAT_RST});
    rdchk("seg_count", TPS_OFS_SEG_COUNT, 32'h1);
    rdchk("status", TPS_OFS_STATUS, 32'h0);
    rdchk("unmapped", 8'h3C, 32'h0);
    // low nibble carries the index so every stored sample differs
    wr(TPS_OFS_MEM_ADDR, 32'h0);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      mem_ref[i] = {s[27:16], 4'(i)};
      wr(TPS_OFS_MEM_DATA, {16'h0, mem_ref[i]});
    end
    wr(TPS_OFS_WAVE_LEN, 32'h3);
    test_end("reset and load");
    wr(TPS_OFS_CFG, 32'h0C);
    wr(TPS_OFS_SW_TRIG, 32'h1);
    repeat (20) @(posedge clk_i);
    chk("generating", 32'h0, {31'h0, generating_o});
    chk("valid", 32'h0, {31'h0, sample_valid_o});
    rdchk("status", TPS_OFS_STATUS, 32'h0);
    test_end("trigger before initiate");
    wr(TPS_OFS_CFG, 32'h04);
    wr(TPS_OFS_CTRL, 32'h1);
    u_src.pulse_ext();
    fork
      play(0, 3, 4, 0, 1'b1);
      begin
        repeat (6) @(posedge clk_i);
        u_src.pulse_ext();
      end
    join
    wr(TPS_OFS_CTRL, 32'h2);
    rdchk("status", TPS_OFS_STATUS, 32'h0);
    test_end("continuous single");
    // stepped, backplane line 5, falling edge; only the low byte lane written
    wr(TPS_OFS_CFG, 32'hB9);
    wb(1'b1, TPS_OFS_REPEAT, 32'h0000AB02, 4'h1, r);
    rdchk("repeat", TPS_OFS_REPEAT, 32'h2);
    wr(TPS_OFS_CTRL, 32'h1);
    for (int k = 0; k < 2; k++) begin
      u_src.pulse_bp(5);
      fork
        play(0, 3, 2, 3, 1'b1);
        begin
          repeat (4) @(posedge clk_i);
          u_src.pulse_bp(5);
        end
      join
    end
    test_end("stepped single");
    wr(TPS_OFS_CTRL, 32'h2);
    wr(TPS_OFS_CFG, 32'h0F);
    wr(TPS_OFS_SEG_COUNT, 32'h2);
    seg(0, 0, 2, 2);
    seg(1, 4, 3, 1);
    wr(TPS_OFS_CTRL, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wr(TPS_OFS_SW_TRIG, 32'h1);
      if (k % 2 == 0) begin
        play(0, 2, 2, 2, 1'b1);
      end else begin
        play(4, 3, 1, 2, 1'b1);
      end
      rdchk("seg_ptr", TPS_OFS_STATUS, {16'h0, 8'((k + 1) % 2), 8'h02});
    end
    test_end("stepped list");
    wr(TPS_OFS_CTRL, 32'h2);
    wr(TPS_OFS_CFG, 32'h02);
    wr(TPS_OFS_CTRL, 32'h1);
    play(0, 2, 2, 0, 1'b1);
    play(4, 3, 1, 0, 1'b0);
    play(0, 2, 2, 0, 1'b0);
    wr(TPS_OFS_CTRL, 32'h2);
    rdchk("status", TPS_OFS_STATUS, 32'h0);
    test_end("continuous list");
    summarize();
  end

endmodule

`default_nettype wire
